// ### rdc_params.svh
// Purpose: Constants of the resolver tracking loop: offsets, fields, resets, timing.
// Assumes: 100 MHz system clock, 32-bit Avalon-MM register slave.
// Notes:   Definitions only; included by the package and the loop.
`ifndef RDC_PARAMS_SVH
`define RDC_PARAMS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RDC_CLK_PERIOD_NS     10
`define RDC_FORCED_TIME_NS    5000000
`define RDC_FORCED_CYCLES     (`RDC_FORCED_TIME_NS / `RDC_CLK_PERIOD_NS)
`define RDC_JUDGE_UNIT_NS     50000
`define RDC_JUDGE_UNIT_CYCLES (`RDC_JUDGE_UNIT_NS / `RDC_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define RDC_OFS_CTRL    8'h00
`define RDC_OFS_GAIN    8'h04
`define RDC_OFS_ANGLE   8'h08
`define RDC_OFS_STATUS  8'h0C
`define RDC_OFS_MASK    8'h10
`define RDC_OFS_STATE   8'h14

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RDC_CTRL_ENABLE   0
`define RDC_CTRL_KI_RESET 1
`define RDC_CTRL_AUTO_BW  2
`define RDC_GAIN_BW_LSB   0
`define RDC_GAIN_JDG_LSB  4
`define RDC_GAIN_MAX_ANGULAR_VELOCITY_SELECT_LSB 8
`define RDC_ST_CONV_ERR   0
`define RDC_ST_TWO_PATH   1
`define RDC_ST_LOW_AMP    2
`define RDC_ST_FORCED_END 3
`define RDC_STATE_BW_LSB  4
`define RDC_STATE_FORCED  8

// ----------------------------------------------------------------
// Reset values and loop constants
// ----------------------------------------------------------------
`define RDC_BW_RST        3'h5
`define RDC_JDG_RST       3'h2
`define RDC_MAX_ANGULAR_VELOCITY_SELECT_RST      3'h1
`define RDC_AGC_MAX       4'hB
`define RDC_KV_NORMAL     4'h4
`define RDC_FORCED_KI_SH  5'h04
`define RDC_FORCED_KP_SH  5'h02
`define RDC_BW_TOP        3'h7
`define RDC_ACC_SH        4
`define RDC_VEL_SH        8
`define RDC_VMAX_BASE     32'h0000_4000
`define RDC_ERR_SMALL     17'h0_0010
`define RDC_ERR_LARGE     17'h0_0400
`define RDC_CONV_ERR_TH   17'h0_1000
`define RDC_TWO_PATH_TH   17'h0_0200
`define RDC_AMP_MIN       12'h200

`endif

// ### rdc_pkg.sv
// Purpose: Types shared by the tracking loop and its table memory.
// Assumes: rdc_params.svh supplies the widths and constants.
// Notes:   All state of the loop and table modules lives in the packed structs below.
package rdc_pkg;
    `include "rdc_params.svh"

    // Sample sequencer states, one-hot
    typedef enum logic [2:0] {
        RDC_ST_IDLE   = 3'b001,
        RDC_ST_LOOKUP = 3'b010,
        RDC_ST_UPDATE = 3'b100
    } rdc_state_t;

    // Table memory state
    typedef struct packed {
        logic signed [11:0] sin_v;
        logic signed [11:0] cos_v;
    } rdc_lut_regs_t;

    // Tracking loop state
    typedef struct packed {
        rdc_state_t         st;
        logic               sync1;
        logic               sync2;
        logic signed [11:0] sin_s;
        logic signed [11:0] cos_s;
        logic               ref_s;
        logic signed [31:0] dev_acc;
        logic signed [15:0] err;
        logic signed [31:0] vel;
        logic [15:0]        angle;
        logic [31:0]        judge_cnt;
        logic [31:0]        forced_cnt;
        logic               forced;
        logic               ki_pend;
        logic [3:0]         agc;
        logic [2:0]         bw;
        logic [11:0]        peak;
        logic               amp_ok;
        logic               enable;
        logic               auto_bw;
        logic [2:0]         bw_sel;
        logic [2:0]         jdg_sel;
        logic [2:0]         max_angular_velocity_select_sel;
        logic [3:0]         status;
        logic [3:0]         mask;
        logic               irq;
        logic [31:0]        rdata;
        logic               waitreq;
    } rdc_regs_t;
endpackage

// ### rdc_lut_if.sv
// Purpose: Carrier between the tracking loop and its trig table.
// Assumes: Table answers one clock after the index changes.
// Notes:   Index is the top seven bits of the held angle.
interface rdc_lut_if;
    logic [6:0]         idx;
    logic signed [11:0] sin_v;
    logic signed [11:0] cos_v;

    modport lut  (input idx, output sin_v, output cos_v);
    modport loop (output idx, input sin_v, input cos_v);
endinterface

// ### rdc_trig_lut.sv
// Purpose: Sine and cosine of the held angle from a quarter-wave table.
// Assumes: 128 steps per turn, amplitude 2047.
// Notes:   Outputs are registered; one clock of latency.
module rdc_trig_lut (
    input  wire logic i_mclk,
    input  wire logic i_rst,
    rdc_lut_if.lut    lut
);
    import rdc_pkg::*;

    rdc_lut_regs_t q;
    rdc_lut_regs_t n;

    // ----------------------------------------------------------------
    // Quarter-wave table
    // ----------------------------------------------------------------
    function automatic logic [11:0] quarter(input logic [5:0] k);
        logic [11:0] t [0:32];
        t = '{12'h000, 12'h064, 12'h0C9, 12'h12C, 12'h18F, 12'h1F1, 12'h252,
              12'h2B2, 12'h30F, 12'h36B, 12'h3C5, 12'h41C, 12'h471, 12'h4C3,
              12'h513, 12'h55F, 12'h5A7, 12'h5ED, 12'h62E, 12'h66C, 12'h6A6,
              12'h6DC, 12'h70D, 12'h73A, 12'h763, 12'h787, 12'h7A7, 12'h7C2,
              12'h7D8, 12'h7E9, 12'h7F5, 12'h7FD, 12'h7FF};
        return t[k];
    endfunction

    // Sine of a seven-bit angle by quadrant folding
    function automatic logic signed [11:0] sine(input logic [6:0] a);
        logic [11:0] m;
        m = a[5] ? quarter(6'h20 - {1'b0, a[4:0]}) : quarter({1'b0, a[4:0]});
        return a[6] ? -$signed(m) : $signed(m);
    endfunction

    // Next state
    always_comb begin
        n       = q;
        n.sin_v = sine(lut.idx);
        n.cos_v = sine(7'(lut.idx + 7'h20));
    end

    // State register
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign lut.sin_v = q.sin_v;
    assign lut.cos_v = q.cos_v;
endmodule

// ### rdc_tracking_loop.sv
// Purpose: Type II tracking loop turning resolver sine/cosine into an angle.
// Assumes: ADC samples arrive on the system clock; excitation polarity is a pin.
// Notes:   Avalon-MM slave with waitrequest; one level interrupt.
// Behaviour
// - Product difference: sine sample times table cosine minus cosine sample times table sine.
// - Synchronous detection against excitation polarity yields deviation input minus held angle.
// - Negative feedback Type II loop drives deviation to zero; held angle is output.
// - Output angle rises or falls with the sign of the deviation.
// - PI compensator gains inside the loop set the loop bandwidth.
// - Bandwidth defaults to 800 Hz after reset and is software selectable.
// - Automatic mode lowers bandwidth on small deviation, raises it on large.
// - Bandwidth shapes step response only; steady speed is held by the integrator.
// - Integral reset on a weak signal tracks it badly; flagged as low amplitude.
// - Forced gain uses twelve-level AGC, starting at velocity gain x128.
// - During forced gain AGC picks velocity gain; integral and proportional gains fixed.
// - Forced gain lasts 5 ms after each integral reset.
// - Conversion error and two-path comparison error are flagged.
//
// The register addresses and register access over Avalon-MM were left to the implementer.
`include "rdc_params.svh"

module rdc_tracking_loop #(
    parameter int unsigned FORCED_CYCLES     = `RDC_FORCED_CYCLES,
    parameter int unsigned JUDGE_UNIT_CYCLES = `RDC_JUDGE_UNIT_CYCLES
) (
    input  wire logic               i_mclk,
    input  wire logic               i_rst,
    input  wire logic [7:0]         i_address,
    input  wire logic               i_read,
    input  wire logic               i_write,
    input  wire logic [31:0]        i_writedata,
    output logic [31:0]             o_readdata,
    output logic                    o_waitrequest,
    input  wire logic               i_sample_valid,
    input  wire logic signed [11:0] i_sin,
    input  wire logic signed [11:0] i_cos,
    input  wire logic               i_exc_ref,
    input  wire logic [15:0]        i_alt_angle,
    output logic [15:0]             o_angle,
    output logic                    o_forced_active,
    output logic                    o_irq
);
    import rdc_pkg::*;

    rdc_regs_t          q;
    rdc_regs_t          n;
    rdc_lut_if          lut ();

    logic               wr_go;
    logic               ki_go;
    logic               tick;
    logic [31:0]        judge_len;
    logic signed [25:0] diff;
    logic signed [31:0] contrib;
    logic signed [15:0] e_now;
    logic [16:0]        e_abs;
    logic [16:0]        pair_abs;
    logic [3:0]         kv_lvl;
    logic [4:0]         ki_sh;
    logic [4:0]         kp_sh;
    logic signed [31:0] vmax;
    logic signed [31:0] vel_sum;
    logic signed [31:0] vel_new;
    logic signed [31:0] prop;
    logic [3:0]         set;
    logic [3:0]         clr;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [16:0] abs17(input logic signed [31:0] x);
        logic signed [16:0] y;
        y = 17'(x);
        return (y < 0) ? 17'(-y) : 17'(y);
    endfunction

    function automatic logic signed [15:0] sat16(input logic signed [31:0] x);
        if (x > 32'sd32767) begin
            return 16'h7FFF;
        end else if (x < -32'sd32768) begin
            return 16'h8000;
        end
        return 16'(x);
    endfunction

    // Deviation scaled by velocity gain level, then by a PI shift
    function automatic logic signed [31:0] gain_term(input logic signed [15:0] e,
                                                     input logic [3:0] lvl,
                                                     input logic [4:0] sh);
        logic signed [31:0] x;
        x = 32'(e) <<< lvl;
        return x >>> (5'h04 + sh);
    endfunction

    // Judgement period in 50 us units
    function automatic logic [5:0] judge_mult(input logic [2:0] s);
        case (s)
            3'h0:    return 6'h01;
            3'h1:    return 6'h02;
            3'h2:    return 6'h04;
            3'h3:    return 6'h08;
            3'h4:    return 6'h0C;
            3'h5:    return 6'h10;
            3'h6:    return 6'h14;
            default: return 6'h20;
        endcase
    endfunction

    function automatic logic [31:0] read_word(input logic [7:0] a);
        logic [31:0] r;
        r = '0;
        if (a == `RDC_OFS_CTRL) begin
            r[`RDC_CTRL_ENABLE]  = q.enable;
            r[`RDC_CTRL_AUTO_BW] = q.auto_bw;
        end else if (a == `RDC_OFS_GAIN) begin
            r[`RDC_GAIN_BW_LSB +: 3]   = q.bw_sel;
            r[`RDC_GAIN_JDG_LSB +: 3]  = q.jdg_sel;
            r[`RDC_GAIN_MAX_ANGULAR_VELOCITY_SELECT_LSB +: 3] = q.max_angular_velocity_select_sel;
        end else if (a == `RDC_OFS_ANGLE) begin
            r[15:0] = q.angle;
        end else if (a == `RDC_OFS_STATUS) begin
            r[3:0] = q.status;
        end else if (a == `RDC_OFS_MASK) begin
            r[3:0] = q.mask;
        end else if (a == `RDC_OFS_STATE) begin
            r[3:0]                    = q.agc;
            r[`RDC_STATE_BW_LSB +: 3] = q.bw;
            r[`RDC_STATE_FORCED]      = q.forced;
        end
        return r;
    endfunction

    // ----------------------------------------------------------------
    // Table memory
    // ----------------------------------------------------------------
    rdc_trig_lut u_lut (
        .i_mclk (i_mclk),
        .i_rst  (i_rst),
        .lut    (lut.lut)
    );

    assign lut.idx = q.angle[15:9];

    // ----------------------------------------------------------------
    // Datapath terms
    // ----------------------------------------------------------------
    // Bus strobes and integral reset request
    assign wr_go = i_write && !q.waitreq;
    assign ki_go = q.enable && (q.ki_pend || (wr_go && i_address == `RDC_OFS_CTRL
                   && i_writedata[`RDC_CTRL_KI_RESET]));
    assign tick  = (q.judge_cnt == 32'h0);
    assign judge_len = 32'(JUDGE_UNIT_CYCLES) * 32'(judge_mult(q.jdg_sel));

    // Product difference and synchronous detection
    assign diff    = 26'(q.sin_s * lut.cos_v) - 26'(q.cos_s * lut.sin_v);
    assign contrib = q.ref_s ? 32'(diff >>> 11) : -32'(diff >>> 11);
    assign e_now   = sat16(q.dev_acc >>> `RDC_ACC_SH);
    assign e_abs   = abs17(32'(e_now));
    assign pair_abs = abs17(32'($signed(16'(q.angle - i_alt_angle))));

    // PI gains: fixed pair with AGC gain while forced, else from bandwidth
    assign kv_lvl = q.forced ? q.agc : `RDC_KV_NORMAL;
    assign kp_sh  = q.forced ? `RDC_FORCED_KP_SH : 5'(`RDC_BW_TOP - q.bw);
    assign ki_sh  = q.forced ? `RDC_FORCED_KI_SH : 5'({`RDC_BW_TOP - q.bw, 1'b0});
    assign vmax   = `RDC_VMAX_BASE <<< q.max_angular_velocity_select_sel;

    // Integral and proportional terms of the compensator
    assign vel_sum = q.vel + gain_term(e_now, kv_lvl, ki_sh);
    assign vel_new = (vel_sum > vmax) ? vmax : (vel_sum < -vmax) ? -vmax : vel_sum;
    assign prop    = gain_term(e_now, kv_lvl, kp_sh);

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        n       = q;
        set     = '0;
        clr     = '0;
        n.sync1 = i_exc_ref;
        n.sync2 = q.sync1;

        // Bus slave: one wait cycle, then answer
        n.waitreq = 1'b1;
        if ((i_read || i_write) && q.waitreq) begin
            n.waitreq = 1'b0;
            n.rdata   = read_word(i_address);
        end
        if (wr_go) begin
            if (i_address == `RDC_OFS_CTRL) begin
                n.enable  = i_writedata[`RDC_CTRL_ENABLE];
                n.auto_bw = i_writedata[`RDC_CTRL_AUTO_BW];
            end else if (i_address == `RDC_OFS_GAIN) begin
                n.bw_sel   = i_writedata[`RDC_GAIN_BW_LSB +: 3];
                n.jdg_sel  = i_writedata[`RDC_GAIN_JDG_LSB +: 3];
                n.max_angular_velocity_select_sel = i_writedata[`RDC_GAIN_MAX_ANGULAR_VELOCITY_SELECT_LSB +: 3];
            end else if (i_address == `RDC_OFS_STATUS) begin
                clr = i_writedata[3:0];
            end else if (i_address == `RDC_OFS_MASK) begin
                n.mask = i_writedata[3:0];
            end
        end

        // Sample sequencer
        case (q.st)
            RDC_ST_IDLE: begin
                if (i_sample_valid && q.enable) begin
                    n.sin_s = i_sin;
                    n.cos_s = i_cos;
                    n.ref_s = q.sync2;
                    n.st    = RDC_ST_LOOKUP;
                end
            end
            RDC_ST_LOOKUP: begin
                n.st = RDC_ST_UPDATE;
            end
            RDC_ST_UPDATE: begin
                n.st = RDC_ST_IDLE;
                if (abs17(32'(q.sin_s)) > 17'(n.peak)) begin
                    n.peak = 12'(abs17(32'(q.sin_s)));
                end
                if (abs17(32'(q.cos_s)) > 17'(n.peak)) begin
                    n.peak = 12'(abs17(32'(q.cos_s)));
                end
            end
            default: begin
                n.st = RDC_ST_IDLE;
            end
        endcase

        // Deviation accumulation and angle integration
        if (q.st == RDC_ST_UPDATE) begin
            n.dev_acc = q.dev_acc + contrib;
            n.angle   = q.angle + 16'(q.vel >>> `RDC_VEL_SH);
        end

        // Judgement period: apply compensator and adapt gains
        if (tick) begin
            n.judge_cnt = judge_len - 32'h1;
            n.err       = e_now;
            n.dev_acc   = (q.st == RDC_ST_UPDATE) ? contrib : 32'sh0;
            n.amp_ok    = (q.peak >= `RDC_AMP_MIN);
            n.peak      = '0;
            if (q.enable) begin
                n.vel   = vel_new;
                n.angle = n.angle + 16'(prop);
            end
            if (q.forced) begin
                if (e_abs > `RDC_ERR_LARGE && q.agc < `RDC_AGC_MAX) begin
                    n.agc = q.agc + 4'h1;
                end else if (e_abs < `RDC_ERR_SMALL && q.agc != 4'h0) begin
                    n.agc = q.agc - 4'h1;
                end
            end else if (q.auto_bw) begin
                if (e_abs > `RDC_ERR_LARGE && q.bw != `RDC_BW_TOP) begin
                    n.bw = q.bw + 3'h1;
                end else if (e_abs < `RDC_ERR_SMALL && q.bw != 3'h0) begin
                    n.bw = q.bw - 3'h1;
                end
            end
            set[`RDC_ST_CONV_ERR] = q.enable && (e_abs > `RDC_CONV_ERR_TH);
            set[`RDC_ST_TWO_PATH] = q.enable && (pair_abs > `RDC_TWO_PATH_TH);
        end else begin
            n.judge_cnt = q.judge_cnt - 32'h1;
        end
        if (!q.auto_bw) begin
            n.bw = q.bw_sel;
        end

        // Forced gain period countdown
        if (q.forced) begin
            if (q.forced_cnt == 32'h0) begin
                n.forced                = 1'b0;
                set[`RDC_ST_FORCED_END] = 1'b1;
            end else begin
                n.forced_cnt = q.forced_cnt - 32'h1;
            end
        end

        // Integral reset starts a forced gain period
        if (ki_go) begin
            n.ki_pend    = 1'b0;
            n.vel        = '0;
            n.dev_acc    = '0;
            n.forced     = 1'b1;
            n.forced_cnt = 32'(FORCED_CYCLES) - 32'h1;
            n.agc        = `RDC_AGC_MAX;
            set[`RDC_ST_LOW_AMP] = !q.amp_ok;
        end

        // Sticky status, set wins over clear
        n.status = (q.status & ~clr) | set;
        n.irq    = |(n.status & n.mask);
    end

    // State register
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            q          <= '0;
            q.st       <= RDC_ST_IDLE;
            q.ki_pend  <= 1'b1;
            q.agc      <= `RDC_AGC_MAX;
            q.bw       <= `RDC_BW_RST;
            q.bw_sel   <= `RDC_BW_RST;
            q.jdg_sel  <= `RDC_JDG_RST;
            q.max_angular_velocity_select_sel <= `RDC_MAX_ANGULAR_VELOCITY_SELECT_RST;
            q.waitreq  <= 1'b1;
        end else begin
            q <= n;
        end
    end

    assign o_readdata      = q.rdata;
    assign o_waitrequest   = q.waitreq;
    assign o_angle         = q.angle;
    assign o_forced_active = q.forced;
    assign o_irq           = q.irq;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_rst);

    bus_answer_a: assert property ((i_read || i_write) && o_waitrequest
        |=> !o_waitrequest ##1 o_waitrequest)
        else $error("bus answer not one cycle after request");
    demod_sign_a: assert property (q.st == RDC_ST_UPDATE && !tick && q.ref_s
        && diff > 26'sd4096 |=> q.dev_acc > $past(q.dev_acc))
        else $error("positive detected deviation did not raise accumulator");
    vel_dir_a: assert property (tick && q.enable && !ki_go && e_now > 16'sd0
        && gain_term(e_now, kv_lvl, ki_sh) > 32'sh0
        && q.vel < vmax |=> q.vel > $past(q.vel))
        else $error("integrator did not follow positive deviation");
    bw_reset_a: assert property ($fell(i_rst) |-> q.bw_sel == `RDC_BW_RST
        && q.bw == `RDC_BW_RST)
        else $error("bandwidth not at default after reset");
    auto_bw_a: assert property (tick && q.auto_bw && !q.forced && q.bw != 3'h0
        && e_abs < `RDC_ERR_SMALL |=> q.bw == $past(q.bw) - 3'h1)
        else $error("automatic bandwidth did not step down");
    agc_start_a: assert property (ki_go |=> q.forced && q.agc == `RDC_AGC_MAX
        && q.vel == 32'sh0)
        else $error("forced gain did not start at top velocity gain");
    agc_fixed_a: assert property (q.forced |-> kp_sh == `RDC_FORCED_KP_SH
        && ki_sh == `RDC_FORCED_KI_SH && kv_lvl == q.agc)
        else $error("forced gain not using fixed PI pair");
    forced_end_a: assert property (q.forced && q.forced_cnt == 32'h0 && !ki_go
        |=> !q.forced && q.status[`RDC_ST_FORCED_END])
        else $error("forced period end not taken");
    low_amp_a: assert property (ki_go && !q.amp_ok |=> q.status[`RDC_ST_LOW_AMP])
        else $error("weak signal at integral reset not flagged");
    irq_level_a: assert property ((q.status & q.mask) != 4'h0 |-> o_irq)
        else $error("unmasked status did not raise interrupt");

    forced_done_c: cover property (q.forced ##1 !q.forced);
    conv_err_c:    cover property (set[`RDC_ST_CONV_ERR]);
    bw_step_c:     cover property (tick && q.auto_bw ##1 q.bw != $past(q.bw));
endmodule

// ### rdc_front_model.sv
// Purpose: Resolver front end: carrier-modulated sine/cosine ADC pair.
// Assumes: Angle to present is given by the bench.
// Notes:   One sample every fourth clock; carrier flips every 8 clocks.
module rdc_front_model (
    input  wire logic          i_mclk,
    input  wire logic [15:0]   i_theta,
    output logic               o_valid = 1'b0,
    output logic signed [11:0] o_sin = 12'h000,
    output logic signed [11:0] o_cos = 12'h000,
    output logic               o_exc = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] ph = 4'h0;
    real        a;
    real        k;
    // Ideal calibrated converter pair, scaled by the excitation sign
    always @(posedge i_mclk) begin
        a = 6.2831853 * i_theta / 65536.0;
        k = ph[3] ? 1500.0 : -1500.0;
        ph <= ph + 4'h1;
        o_valid <= (ph[1:0] == 2'h0);
        // Reference leads the samples by the loop's two-stage synchroniser
        o_exc <= (ph >= 4'h6) && (ph <= 4'hD);
        o_sin <= 12'($rtoi(k * $sin(a)));
        o_cos <= 12'($rtoi(k * $cos(a)));
    end
endmodule

// ### tb_rdc_tracking_loop.sv
// Purpose: Self-checking bench of the tracking loop.
// Assumes: Short forced and judgement counts.
// Notes:   Avalon master tasks, one task per scenario.
module tb_rdc_tracking_loop;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0, rst = 1'b1, rd_s = 1'b0, wr_s = 1'b0, wreq, vld, exc, frc, irq;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, q;
    logic signed [11:0] sn, cs;
    logic [15:0] theta = 16'h3000, ang;
    logic [31:0] ang_p = 32'h0;
    int failures = 0, checks_done = 0, cyc = 0, n;
    rdc_front_model fe_u (.i_mclk(mclk), .i_theta(theta), .o_valid(vld), .o_sin(sn),
        .o_cos(cs), .o_exc(exc));
    rdc_tracking_loop #(.FORCED_CYCLES(200), .JUDGE_UNIT_CYCLES(8)) dut_u (.i_mclk(mclk),
        .i_rst(rst), .i_address(addr), .i_read(rd_s), .i_write(wr_s), .i_writedata(wdata),
        .o_readdata(rdata), .o_waitrequest(wreq), .i_sample_valid(vld), .i_sin(sn),
        .i_cos(cs), .i_exc_ref(exc), .i_alt_angle(theta), .o_angle(ang),
        .o_forced_active(frc), .o_irq(irq));
    initial forever #5 mclk = ~mclk;
    // Angle history, lines up with the word a register read returns
    always @(posedge mclk) ang_p <= {ang_p[15:0], ang};
    // Hang guard
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            failures++;
            stop_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Hold the request until waitrequest is seen low, then release
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr_s <= w;
        rd_s <= !w;
        do @(posedge mclk); while (wreq !== 1'b0);
        q = rdata;
        wr_s <= 1'b0;
        rd_s <= 1'b0;
        @(posedge mclk);
    endtask
    function automatic logic near(input logic [15:0] e);
        return (e < 16'h0400) || (e > 16'hFC00);
    endfunction
    task automatic t_defaults;
        bus(0, 8'h04, 0);
        chk(q, 32'h0000_0125);
        bus(0, 8'h20, 0);
        chk(q, 32'h0);
    endtask
    task automatic t_forced;
        bus(1, 8'h04, 32'h0000_0175);
        bus(1, 8'h10, 32'h0000_0008);
        bus(1, 8'h00, 32'h0000_0001);
        n = 0;
        bus(0, 8'h14, 0);
        chk({q[8], q[3:0]}, 5'h1B);
        bus(1, 8'h04, 32'h0000_0055);
        bus(0, 8'h04, 0);
        chk(q, 32'h0000_0055);
        while (frc === 1'b1 && n < 400) begin
            @(posedge mclk);
            n++;
        end
        chk(n > 170 && n < 201, 1'b1);
        repeat (3) @(posedge mclk);
        chk(irq, 1'b1);
        bus(0, 8'h0C, 0);
        chk(q[3:2], 2'h3);
        bus(1, 8'h04, 32'h0000_0125);
        bus(1, 8'h0C, 32'h0000_0008);
        repeat (2) @(posedge mclk);
        chk(irq, 1'b0);
    endtask
    task automatic t_track(input logic [15:0] t);
        bus(1, 8'h04, 32'h0000_0127);
        theta <= t;
        repeat (8000) @(posedge mclk);
        chk(near(ang - t), 1'b1);
        bus(0, 8'h08, 0);
        chk(q[15:0], ang_p[31:16]);
    endtask
    // Automatic bandwidth steps down from the software code while locked
    task automatic t_auto;
        bus(1, 8'h00, 32'h0000_0005);
        repeat (400) @(posedge mclk);
        bus(0, 8'h14, 0);
        chk(q[6:4] < 3'h7, 1'b1);
    endtask
    initial begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        t_defaults();
        t_forced();
        t_track(16'h3000);
        t_track(16'hF000);
        t_auto();
        stop_test();
    end
endmodule
